// ---- rcg_pkg.sv ----
package rcg_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] ENABLE_WORD_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] GATE_STATUS_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] WRITE_FAULT_OFS = 12'h008;

	// enable word field positions
	localparam int unsigned ESSENTIAL_BIT = 0;
	localparam int unsigned ENGINE_CPU_BIT = 1;
	localparam int unsigned ENGINE_MEM_BIT = 2;
	localparam int unsigned MODEM_BIT = 3;
	localparam int unsigned MODEM_MEM_BIT = 4;
	localparam int unsigned RF_ENGINE_BIT = 5;
	localparam int unsigned RF_ENGINE_MEM_BIT = 6;
	localparam int unsigned RADIO_TIMER_BIT = 7;
	localparam int unsigned PACKET_BIT = 8;
	localparam int unsigned SYNTH_CAL_BIT = 9;
	localparam int unsigned TRACER_BIT = 10;
	localparam int unsigned RESERVED_LSB = 11;

	// number of gated clocks, essential one included
	localparam int unsigned GATE_COUNT = 11;

	// reset values
	localparam logic [DATA_W-1:0] ENABLE_WORD_RESET = 32'h0000_0001;
	localparam logic [GATE_COUNT-1:0] ENABLE_FIELD_RESET = 11'h001;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

	// write fault register fields
	localparam int unsigned FAULT_RESERVED_BIT = 0;
	localparam int unsigned FAULT_ESSENTIAL_BIT = 1;
	localparam int unsigned FAULT_W = 2;
	localparam logic [FAULT_W-1:0] FAULT_RESET = 2'h0;

	typedef enum logic [0:0] {
		RCG_IDLE,
		RCG_ACK
	} rcg_bus_state_t;

endpackage

// ---- rcg_clock_gate.sv ----
`timescale 1ns/1ps

// latch-based gate: enable only changes while clock is low
module rcg_clock_gate (
	// clock in
	input wire logic clk_in,
	// gate control
	input wire logic enable,
	// gated clock
	output logic clk_out
);

	logic en_latch;

	always_latch begin
		if (!clk_in) begin
			en_latch <= enable;
		end
	end

	assign clk_out = clk_in & en_latch;

endmodule

// ---- rcg_radio_clock_gating.sv ----
`timescale 1ns/1ps

module rcg_radio_clock_gating (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rcg_pkg::ADDR_W-1:0] paddr,
	input wire logic [rcg_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [rcg_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// gated clocks
	output logic essential_interface_clock_gate_clk,
	output logic command_packet_engine_clk,
	output logic command_packet_memory_clock_gate_clk,
	output logic modem_clock_gate_clk,
	output logic modem_memory_clock_gate_clk,
	output logic rf_engine_clock_gate_clk,
	output logic rf_engine_memory_clock_gate_clk,
	output logic radio_timer_clock_gate_clk,
	output logic packet_handling_engine_clock_gate_clk,
	output logic synth_cal_engine_clock_gate_clk,
	output logic tracer_clock_gate_clk
);

	typedef struct packed {
		rcg_pkg::rcg_bus_state_t state;
		logic [rcg_pkg::GATE_COUNT-1:0] enables;
		logic [rcg_pkg::FAULT_W-1:0] faults;
		logic [rcg_pkg::DATA_W-1:0] rdata;
		logic err;
	} rcg_state_t;

	rcg_state_t state_q;
	rcg_state_t state_d;

	logic [rcg_pkg::GATE_COUNT-1:0] gate_en;
	logic [rcg_pkg::GATE_COUNT-1:0] gate_clk;

	logic setup;
	logic commit;
	logic hit_enable;
	logic hit_status;
	logic hit_fault;
	logic mapped;
	logic bad_access;
	logic low_lane;
	logic high_lane;
	logic [rcg_pkg::DATA_W-1:0] word_view;
	logic [rcg_pkg::DATA_W-1:0] read_mux;
	logic [rcg_pkg::GATE_COUNT-1:0] write_field;
	logic reserved_dirty;
	logic essential_drop;

	// address decode
	always_comb begin
		hit_enable = (paddr == rcg_pkg::ENABLE_WORD_OFS);
		hit_status = (paddr == rcg_pkg::GATE_STATUS_OFS);
		hit_fault = (paddr == rcg_pkg::WRITE_FAULT_OFS);
		mapped = hit_enable | hit_status | hit_fault;
		bad_access = !mapped | (pwrite & hit_status);
	end

	// phase tracking
	always_comb begin
		setup = psel & penable & (state_q.state == rcg_pkg::RCG_IDLE);
		commit = psel & penable & (state_q.state == rcg_pkg::RCG_ACK);
	end

	// byte lanes holding the writable fields
	always_comb begin
		low_lane = pstrb[0];
		high_lane = pstrb[1];
	end

	// full enable word as software sees it
	always_comb begin
		word_view = rcg_pkg::ZERO_WORD;
		word_view[rcg_pkg::TRACER_BIT:rcg_pkg::ESSENTIAL_BIT] = state_q.enables;
		word_view[rcg_pkg::ESSENTIAL_BIT] = 1'b1;
	end

	// new field value from a write, lane by lane
	always_comb begin
		write_field = state_q.enables;
		if (low_lane) begin
			write_field[rcg_pkg::RADIO_TIMER_BIT:rcg_pkg::ENGINE_CPU_BIT] =
				pwdata[rcg_pkg::RADIO_TIMER_BIT:rcg_pkg::ENGINE_CPU_BIT];
		end
		if (high_lane) begin
			write_field[rcg_pkg::TRACER_BIT:rcg_pkg::PACKET_BIT] =
				pwdata[rcg_pkg::TRACER_BIT:rcg_pkg::PACKET_BIT];
		end
		write_field[rcg_pkg::ESSENTIAL_BIT] = 1'b1;
	end

	// write hygiene checks
	always_comb begin
		reserved_dirty = |pwdata[rcg_pkg::DATA_W-1:rcg_pkg::RESERVED_LSB];
		essential_drop = low_lane & !pwdata[rcg_pkg::ESSENTIAL_BIT];
	end

	// read data selection
	always_comb begin
		read_mux = rcg_pkg::ZERO_WORD;
		if (hit_enable) begin
			read_mux = word_view;
		end else if (hit_status) begin
			read_mux[rcg_pkg::GATE_COUNT-1:0] = gate_en;
		end else if (hit_fault) begin
			read_mux[rcg_pkg::FAULT_W-1:0] = state_q.faults;
		end
	end

	// next state
	always_comb begin
		state_d = state_q;
		case (state_q.state)
			rcg_pkg::RCG_IDLE: begin
				if (setup) begin
					state_d.state = rcg_pkg::RCG_ACK;
					state_d.err = bad_access;
					if (!pwrite) begin
						state_d.rdata = read_mux;
					end
				end
			end
			rcg_pkg::RCG_ACK: begin
				state_d.state = rcg_pkg::RCG_IDLE;
				state_d.err = 1'b0;
				if (commit && pwrite && !bad_access) begin
					if (hit_enable) begin
						state_d.enables = write_field;
					end
				end
			end
			default: begin
				state_d.state = rcg_pkg::RCG_IDLE;
				state_d.err = 1'b0;
			end
		endcase
		// sticky faults: writing one clears, a new fault wins
		if (commit && pwrite && hit_fault) begin
			state_d.faults = state_q.faults & ~pwdata[rcg_pkg::FAULT_W-1:0];
		end
		if (commit && pwrite && hit_enable) begin
			if (reserved_dirty) begin
				state_d.faults[rcg_pkg::FAULT_RESERVED_BIT] = 1'b1;
			end
			if (essential_drop) begin
				state_d.faults[rcg_pkg::FAULT_ESSENTIAL_BIT] = 1'b1;
			end
		end
		if (!psel) begin
			state_d.state = rcg_pkg::RCG_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q.state <= rcg_pkg::RCG_IDLE;
			state_q.enables <= rcg_pkg::ENABLE_FIELD_RESET;
			state_q.faults <= rcg_pkg::FAULT_RESET;
			state_q.rdata <= rcg_pkg::ZERO_WORD;
			state_q.err <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// apb answer, one wait state
	assign pready = (state_q.state == rcg_pkg::RCG_ACK);
	assign pslverr = pready & state_q.err;
	assign prdata = state_q.rdata;

	// gate enables; essential one cannot be lowered
	always_comb begin
		gate_en = state_q.enables;
		gate_en[rcg_pkg::ESSENTIAL_BIT] = 1'b1;
	end

	// cpu and memory enables are independent here, software pairs them
	genvar gi;
	generate
		for (gi = 0; gi < rcg_pkg::GATE_COUNT; gi++) begin : g_gate
			rcg_clock_gate u_gate (
				.clk_in(pclk),
				.enable(gate_en[gi]),
				.clk_out(gate_clk[gi])
			);
		end
	endgenerate

	// clock fan-out
	assign essential_interface_clock_gate_clk = gate_clk[rcg_pkg::ESSENTIAL_BIT];
	assign command_packet_engine_clk = gate_clk[rcg_pkg::ENGINE_CPU_BIT];
	assign command_packet_memory_clock_gate_clk = gate_clk[rcg_pkg::ENGINE_MEM_BIT];
	assign modem_clock_gate_clk = gate_clk[rcg_pkg::MODEM_BIT];
	assign modem_memory_clock_gate_clk = gate_clk[rcg_pkg::MODEM_MEM_BIT];
	assign rf_engine_clock_gate_clk = gate_clk[rcg_pkg::RF_ENGINE_BIT];
	assign rf_engine_memory_clock_gate_clk = gate_clk[rcg_pkg::RF_ENGINE_MEM_BIT];
	assign radio_timer_clock_gate_clk = gate_clk[rcg_pkg::RADIO_TIMER_BIT];
	assign packet_handling_engine_clock_gate_clk = gate_clk[rcg_pkg::PACKET_BIT];
	assign synth_cal_engine_clock_gate_clk = gate_clk[rcg_pkg::SYNTH_CAL_BIT];
	assign tracer_clock_gate_clk = gate_clk[rcg_pkg::TRACER_BIT];

endmodule

// ---- rcg_props.sv ----
`timescale 1ns/1ps
module rcg_props (
	// apb side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// gated clocks
	input wire logic essential_interface_clock_gate_clk,
	input wire logic command_packet_engine_clk,
	input wire logic modem_clock_gate_clk,
	input wire logic tracer_clock_gate_clk
);
	// mid-cycle sampling sees the gated clocks' high phase
	default clocking @(negedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable && pready;
	wire wr0 = acc && pwrite && paddr == 12'h000;
	property p_ess; essential_interface_clock_gate_clk; endproperty
	a_ess: assert property (p_ess) else $error("essential clock stopped");
	property p_rd; acc && !pwrite && paddr == 12'h000 |-> prdata[31:11] == 21'h0 && prdata[0]; endproperty
	a_rd: assert property (p_rd) else $error("fixed bits of enable word wrong");
	property p_cpe; wr0 && pstrb[0] |-> ##2 command_packet_engine_clk == $past(pwdata[1], 2); endproperty
	a_cpe: assert property (p_cpe) else $error("engine clock not following bit 1");
	property p_mdm; wr0 && pstrb[0] |-> ##2 modem_clock_gate_clk == $past(pwdata[3], 2); endproperty
	a_mdm: assert property (p_mdm) else $error("modem clock not following bit 3");
	property p_trc; wr0 && pstrb[1] |-> ##2 tracer_clock_gate_clk == $past(pwdata[10], 2); endproperty
	a_trc: assert property (p_trc) else $error("tracer clock not following bit 10");
	property p_rdy; psel && !penable |=> !pready ##1 pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready not on second access cycle");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready longer than one cycle");
	property p_err; acc && paddr > 12'h008 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_ok; wr0 |-> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("enable word write refused");
endmodule
bind rcg_radio_clock_gating rcg_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .essential_interface_clock_gate_clk(essential_interface_clock_gate_clk),
	.command_packet_engine_clk(command_packet_engine_clk), .modem_clock_gate_clk(modem_clock_gate_clk),
	.tracer_clock_gate_clk(tracer_clock_gate_clk));

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, ew;
	logic [3:0] pstrb = 4'h0;
	wire [10:0] g;
	int mismatches = 0, comparisons = 0, seed = 32'hE49EBDE4;
	always #25 pclk = ~pclk;
	rcg_radio_clock_gating i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .essential_interface_clock_gate_clk(g[0]), .command_packet_engine_clk(g[1]),
		.command_packet_memory_clock_gate_clk(g[2]), .modem_clock_gate_clk(g[3]),
		.modem_memory_clock_gate_clk(g[4]), .rf_engine_clock_gate_clk(g[5]),
		.rf_engine_memory_clock_gate_clk(g[6]), .radio_timer_clock_gate_clk(g[7]),
		.packet_handling_engine_clock_gate_clk(g[8]), .synth_cal_engine_clock_gate_clk(g[9]),
		.tracer_clock_gate_clk(g[10]));
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		comparisons++;
		if (v !== e) begin
			mismatches++;
			$display("Error %0t: got %h expected %h", $time, v, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] nxt(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
		nxt = o;
		if (s[0]) nxt[7:1] = d[7:1];
		if (s[1]) nxt[10:8] = d[10:8];
	endfunction
	// write, then see the clocks and read back word and status
	task automatic wr0(input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, 12'h000, d, s);
		chk({31'h0, er}, 32'h0);
		ew = nxt(ew, d, s);
		@(posedge pclk);
		#5 chk({21'h0, g}, ew);
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk(rd, ew);
		apb(1'b0, 12'h004, 32'h0, 4'h0);
		chk(rd, ew);
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#(4000 * 50);
		mismatches++;
		summarize;
	end
	initial begin
		ew = 32'h0000_0001;
		repeat (8) @(posedge pclk);
		#5 chk({21'h0, g}, 32'h1);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk(rd, 32'h1);
		$display("test reset done");
		wr0(32'hFFFF_FFFF, 4'hF);
		wr0(32'h0000_0000, 4'hF);
		wr0(32'h0000_0006, 4'h1);
		// sticky write faults: both set by now, write one clears
		apb(1'b0, 12'h008, 32'h0, 4'h0);
		chk(rd, 32'h3);
		apb(1'b1, 12'h008, 32'h1, 4'hF);
		chk({31'h0, er}, 32'h0);
		apb(1'b0, 12'h008, 32'h0, 4'h0);
		chk(rd, 32'h2);
		$display("test faults done");
		for (int i = 0; i < 24; i++) wr0($random(seed), 4'($random(seed)));
		$display("test random done");
		// reset in mid-run must bring back the reset word
		@(posedge pclk);
		presetn <= 1'b0;
		ew = 32'h0000_0001;
		repeat (2) @(posedge pclk);
		#5 chk({21'h0, g}, ew);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk(rd, ew);
		apb(1'b0, 12'h008, 32'h0, 4'h0);
		chk(rd, 32'h0);
		$display("test mid reset done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, i == 0 ? 12'h00C : i == 1 ? 12'h004 : 12'hFFC, 32'hFFFF_FFFF, 4'hF);
			chk({31'h0, er}, 32'h1);
		end
		apb(1'b0, 12'h00C, 32'h0, 4'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk(rd, ew);
		$display("test refused done");
		summarize;
	end
endmodule
